// ==== dv/pad_board.sv ====
// Board model for the second GPIO port: resolves each pad level.
// Assumes the bench drives only pads that the port has released.
`timescale 1ns/1ps
module pad_board (
  input  wire logic       sys_clk_i,   // Bench clock
  input  wire logic [7:0] pad_out_i,   // Port drive value
  input  wire logic [7:0] pad_oe_n_i,  // Low while port drives
  input  wire logic [7:0] pullup_en_i, // Weak pull-ups on
  input  wire logic [7:0] ext_val_i,   // Board drive value
  input  wire logic [7:0] ext_drv_i,   // Board drives pad
  output logic [7:0]      pad_o        // Resolved level
);
  logic [7:0] float_q = 8'h5a;

  // Undriven pads wander, so a stale level never reads as valid
  always_ff @(posedge sys_clk_i) begin
    float_q <= ~pad_o;
  end

  // Port drive wins, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n_i[i]) pad_o[i] = pad_out_i[i];
      else if (ext_drv_i[i]) pad_o[i] = ext_val_i[i];
      else if (pullup_en_i[i]) pad_o[i] = 1'b1;
      else pad_o[i] = float_q[i];
    end
  end
endmodule

// ==== dv/tb_port_b_gpio.sv ====
// Self-checking bench for the second GPIO port, random data, fixed seed.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps
module tb_port_b_gpio;
  logic sys_clk_i = 1'b0;
  logic arst_n = 1'b0;
  port_b_gpio_pkg::reg_req_t req = '0;
  logic [7:0] rdata, pad_in, pad_out, pad_oe_n, pullup_en, ext_val, ext_drv;
  logic [4:0] analog_en;
  logic adc_cfg = 1'b1;
  logic cap_sel = 1'b1;
  logic ccp_out = 1'b0;
  logic ccp_in, irq0, irq1, irq2, fault, flag, wake;
  int n_tests = 0;
  int fail_count = 0;
  int unsigned seed;

  // Free-running 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  port_b_gpio dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n), .req_i(req), .rdata_o(rdata),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(pad_oe_n), .pullup_en_o(pullup_en),
    .analog_en_o(analog_en), .analog_default_config_i(adc_cfg),
    .capture_pin_select_i(cap_sel), .capture_compare_unit_two_out_i(ccp_out),
    .capture_compare_unit_two_in_o(ccp_in), .ext_irq_in_zero_o(irq0),
    .ext_irq_in_one_o(irq1), .ext_irq_in_two_o(irq2), .pwm_fault_input_o(fault),
    .port_change_flag_o(flag), .wake_o(wake));

  pad_board board (.sys_clk_i(sys_clk_i), .pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n),
    .pullup_en_i(pullup_en), .ext_val_i(ext_val), .ext_drv_i(ext_drv), .pad_o(pad_in));

  // Digital read of the pads: analog pins read as zero
  function automatic logic [7:0] rdexp(input logic [7:0] p, input logic [7:0] m);
    return p & ~m;
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // One-cycle write strobe; mm marks a memory-move destination
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic mm);
    @(posedge sys_clk_i);
    req.addr <= a;
    req.wdata <= d;
    req.mem_move <= mm;
    req.wr <= 1'b1;
    @(posedge sys_clk_i);
    req.wr <= 1'b0;
    req.mem_move <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk_i);
    req.rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask

  task automatic pin(input logic [7:0] v, input logic [7:0] drv);
    @(posedge sys_clk_i);
    ext_val <= v;
    ext_drv <= drv;
    #1;
  endtask

  task automatic wait_flag();
    int k = 0;
    while (flag !== 1'b1 && k < 20) begin
      cyc(1);
      k++;
    end
    if (flag !== 1'b1) begin
      chk("flag wait", 8'h01, {7'h0, flag});
      test_done();
    end
  endtask

  // Hang guard
  initial begin
    #500000;
    fail_count++;
    test_done();
  end

  initial begin
    logic [7:0] d, l, ev, am, pe, e;
    ext_val = 8'h00;
    ext_drv = 8'hff;
    seed = $urandom(81);
    // Two power-ups: analog default with pin 3 plain, then digital with capture on pin 3
    for (int cfg = 0; cfg < 2; cfg++) begin
      ev = 8'($urandom);
      am = (cfg == 0) ? 8'h1f : 8'h00;
      @(posedge sys_clk_i);
      arst_n <= 1'b0;
      adc_cfg <= (cfg == 0);
      cap_sel <= (cfg == 0);
      ccp_out <= 1'($urandom);
      ext_val <= ev;
      ext_drv <= 8'hff;
      repeat (2) @(posedge sys_clk_i);
      arst_n <= 1'b1;
      cyc(6);
      chk("analog_en", am, {3'h0, analog_en});
      chk("pullup_en", 8'h00, pullup_en);
      chk("pad_oe_n", 8'hff, pad_oe_n);
      rchk("direction", 8'h04, 8'hff);
      rchk("latch", 8'h08, 8'h00);
      rchk("second ctl", 8'h10, 8'h80);
      // Snapshot starts at zero, so any high digital upper pin raises the flag
      rchk("main ctl", 8'h0c, {7'h0, |(ev[7:4] & ~am[7:4])});
      rchk("unmapped", 8'h20, 8'h00);
      rchk("data", 8'h00, rdexp(ev, am));
      e = rdexp(ev, am);
      chk("ext irqs", {5'h0, e[2:0]}, {5'h0, irq2, irq1, irq0});
      chk("fault", {7'h0, e[0]}, {7'h0, fault});
      chk("capture in", (cfg == 1) ? {7'h0, ev[3]} : 8'h00, {7'h0, ccp_in});
      // Random direction and latch, board drives only the input pins
      d = 8'($urandom);
      l = 8'($urandom);
      ev = 8'($urandom);
      // Pin 3 driven while the capture unit owns it
      if (cfg == 1) d[3] = 1'b0;
      pin(ev, d);
      wr(8'h08, l, 1'b0);
      wr(8'h04, d, 1'b0);
      cyc(1);
      pe = l;
      if (cfg == 1) pe[3] = ccp_out;
      chk("pad_oe_n", d, pad_oe_n);
      chk("pad_out", pe & ~d, pad_out & ~d);
      rchk("latch rmw", 8'h08, l);
      wr(8'h10, 8'h00, 1'b0);
      cyc(1);
      chk("pullup on", d, pullup_en);
      wr(8'h10, 8'h80, 1'b0);
      cyc(1);
      chk("pullup off", 8'h00, pullup_en);
      wr(8'h14, 8'h00, 1'b0);
      cyc(5);
      rchk("data digital", 8'h00, (ev & d) | (pe & ~d));
      // Change detection on the upper pins
      wr(8'h04, 8'hff, 1'b0);
      wr(8'h10, 8'h00, 1'b0);
      cyc(1);
      chk("pullup all", 8'hff, pullup_en);
      pin(ev, 8'hff);
      wr(8'h0c, 8'h08, 1'b0);
      cyc(6);
      rchk("snapshot read", 8'h00, ev);
      wr(8'h0c, 8'h08, 1'b0);
      chk("flag idle", 8'h00, {7'h0, flag});
      ev[3] = ~ev[3];
      pin(ev, 8'hff);
      cyc(8);
      chk("flag pin3", 8'h00, {7'h0, flag});
      ev[7] = ~ev[7];
      pin(ev, 8'hff);
      wait_flag();
      cyc(1);
      chk("wake", 8'h01, {7'h0, wake});
      wr(8'h0c, 8'h08, 1'b0);
      chk("flag held", 8'h01, {7'h0, flag});
      wr(8'h00, l, 1'b1);
      wr(8'h0c, 8'h08, 1'b0);
      chk("flag mem move", 8'h01, {7'h0, flag});
      rchk("data access", 8'h00, ev);
      wr(8'h0c, 8'h08, 1'b0);
      chk("flag cleared", 8'h00, {7'h0, flag});
      ev[5] = ~ev[5];
      pin(ev, 8'hff);
      wait_flag();
      ev[5] = ~ev[5];
      pin(ev, 8'hff);
      cyc(6);
      wr(8'h0c, 8'h08, 1'b0);
      chk("flag returned", 8'h00, {7'h0, flag});
      ev[6] = ~ev[6];
      pin(ev, 8'hff);
      wait_flag();
      wr(8'h00, l, 1'b0);
      wr(8'h0c, 8'h08, 1'b0);
      chk("flag data write", 8'h00, {7'h0, flag});
      // Upper pin turned output and toggled stays out of the compare
      wr(8'h08, {~ev[7], 7'h00}, 1'b0);
      wr(8'h04, 8'h7f, 1'b0);
      pin(ev, 8'h7f);
      cyc(8);
      chk("flag output pin", 8'h00, {7'h0, flag});
      chk("wake off", 8'h00, {7'h0, wake});
    end
    test_done();
  end
endmodule

// ==== logic/port_b_gpio.sv ====
// Second 8-bit GPIO port: direction, output latch, shared pull-ups,
// analog default on pins 4..0 and change detection on pins 7..4.
// Assumes pads resolved outside from pad_out/pad_oe_n; strap inputs are static.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// - Eight pins, each with its own direction bit and output latch bit.
// - Direction bit one releases the pin driver so the pin is an input.
// - Direction bit zero drives the pin from its output latch bit, except pin 3 under capture select zero.
// - Latch register is mapped; reading it returns latched values, not pins.
// - Clearing pull-up disable bit 7 of second control enables the pull-ups of all input pins.
// - A pin set as output never has its pull-up on.
// - Pull-ups are off after power-on reset.
// - Analog default set: pins 4..0 analog reading zero, pins 7..5 digital.
// - Analog default clear: pins 4..0 come up as digital inputs.
// - Only pins 7..4 are compared; output pins are left out.
// - Input pins compare against a snapshot taken at last data access.
// - Mismatches of pins 7..4 are ORed into flag bit 0 of main control.
// - A raised change interrupt wakes the device from sleep or idle.
// - A persisting mismatch keeps setting the flag over a software clear.
// - Access data, wait one cycle, then clear; the access ends the mismatch.
// - Memory-move writes to data do not refresh the snapshot; others do.
// - A pin returning to its snapshot value ends its mismatch by itself.
// - Capture select zero routes pin 3 to the second capture/compare unit.
// - Analog pins block the digital input path; digital output unaffected.
// - Input pins 0..2 feed external interrupts; pin 0 feeds the PWM fault.
module port_b_gpio (
  input  wire logic                       sys_clk_i,                        // 100 MHz clock
  input  wire logic                       arst_n_i,                         // Async reset, low
  input  wire port_b_gpio_pkg::reg_req_t  req_i,                            // Register request
  output logic [7:0]                      rdata_o,                          // Read data, +1 cycle
  input  wire logic [7:0]                 pad_in_i,                         // Pad levels
  output logic [7:0]                      pad_out_o,                        // Pad drive value
  output logic [7:0]                      pad_oe_n_o,                       // Low while driving
  output logic [7:0]                      pullup_en_o,                      // Weak pull-up on
  output logic [4:0]                      analog_en_o,                      // Analog mode pins
  input  wire logic                       analog_default_config_i,          // Analog strap
  input  wire logic                       capture_pin_select_i,             // Capture pin strap
  input  wire logic                       capture_compare_unit_two_out_i,   // Compare/PWM out
  output logic                            capture_compare_unit_two_in_o,    // Capture input
  output logic                            ext_irq_in_zero_o,                // Ext interrupt 0
  output logic                            ext_irq_in_one_o,                 // Ext interrupt 1
  output logic                            ext_irq_in_two_o,                 // Ext interrupt 2
  output logic                            pwm_fault_input_o,                // PWM fault input
  output logic                            port_change_flag_o,               // Change flag
  output logic                            wake_o                            // Wake request
);

  logic [7:0]                      sync1_q;
  logic [7:0]                      sync2_q;
  logic [7:0]                      sync3_q;
  logic [7:0]                      filt_q;
  logic [7:0]                      dir_q;
  logic [7:0]                      latch_q;
  logic                            pullup_dis_n_q;
  logic [4:0]                      analog_q;
  logic                            capture_sel_q;
  port_b_gpio_pkg::cfg_state_t     cfg_state_q;
  logic [3:0]                      snap_q;
  logic                            flag_q;
  logic                            change_en_q;
  logic [7:0]                      rdata_q;
  logic [7:0]                      pad_out_q;
  logic [7:0]                      pad_oe_n_q;
  logic [7:0]                      pullup_q;
  logic [4:0]                      analog_en_q;
  logic [2:0]                      ext_irq_q;
  logic                            fault_q;
  logic                            capture_in_q;
  logic                            wake_q;
  logic [7:0]                      pin_val;
  logic [3:0]                      mismatch_vec;
  logic                            mismatch_any;
  logic                            data_access;
  logic                            wr_data;
  logic                            wr_dir;
  logic                            wr_latch;
  logic                            wr_main;
  logic                            wr_second;
  logic                            wr_analog;

  // Address decode of the register port
  assign wr_data   = req_i.wr && (req_i.addr == port_b_gpio_pkg::OFS_PORT_DATA);
  assign wr_dir    = req_i.wr && (req_i.addr == port_b_gpio_pkg::OFS_DIRECTION);
  assign wr_latch  = req_i.wr && (req_i.addr == port_b_gpio_pkg::OFS_LATCH);
  assign wr_main   = req_i.wr && (req_i.addr == port_b_gpio_pkg::OFS_MAIN_INT);
  assign wr_second = req_i.wr && (req_i.addr == port_b_gpio_pkg::OFS_SECOND_INT);
  assign wr_analog = req_i.wr && (req_i.addr == port_b_gpio_pkg::OFS_ANALOG_SEL);

  // Three-stage pad synchroniser; stage one feeds stage two only
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
    end else begin
      sync1_q <= pad_in_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Accept a pin change once stages two and three agree
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filt_q <= 8'h00;
    end else begin
      filt_q <= (~(sync2_q ^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & filt_q);
    end
  end

  // Analog pins read as zero; the digital input buffer is cut off there
  assign pin_val = filt_q & ~{3'h0, analog_q};

  // Direction register, all inputs out of reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_q <= port_b_gpio_pkg::DIR_RST;
    end else if (wr_dir) begin
      dir_q <= req_i.wdata;
    end
  end

  // Output latch; both the data and latch addresses write it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_q <= port_b_gpio_pkg::LATCH_RST;
    end else if (wr_data || wr_latch) begin
      latch_q <= req_i.wdata;
    end
  end

  // Shared active-low pull-up control, off after reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pullup_dis_n_q <= port_b_gpio_pkg::PULLUP_DIS_RST;
    end else if (wr_second) begin
      pullup_dis_n_q <= req_i.wdata[port_b_gpio_pkg::PULLUP_DIS_BIT];
    end
  end

  // Straps are caught once, the cycle after reset release, never by the reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_state_q   <= port_b_gpio_pkg::CFG_WAIT;
      analog_q      <= port_b_gpio_pkg::ANALOG_ON;
      capture_sel_q <= port_b_gpio_pkg::CAPTURE_RST;
    end else begin
      case (cfg_state_q)
        port_b_gpio_pkg::CFG_WAIT: begin
          analog_q      <= analog_default_config_i ? port_b_gpio_pkg::ANALOG_ON
                                                   : port_b_gpio_pkg::ANALOG_OFF;
          capture_sel_q <= capture_pin_select_i;
          cfg_state_q   <= port_b_gpio_pkg::CFG_DONE;
        end
        port_b_gpio_pkg::CFG_DONE: begin
          if (wr_analog) begin
            analog_q <= req_i.wdata[4:0];
          end
        end
        default: begin
          cfg_state_q <= port_b_gpio_pkg::CFG_WAIT;
        end
      endcase
    end
  end

  // Any read or write of data refreshes the snapshot, except a memory move
  assign data_access = (req_i.rd && (req_i.addr == port_b_gpio_pkg::OFS_PORT_DATA))
                    || (wr_data && !req_i.mem_move);

  // Snapshot of the upper four pins at the most recent data access
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      snap_q <= 4'h0;
    end else if (data_access) begin
      snap_q <= pin_val[7:4];
    end
  end

  // Output pins drop out; a pin back at its snapshot clears by itself
  assign mismatch_vec = (pin_val[7:4] ^ snap_q) & dir_q[7:4];
  assign mismatch_any = |mismatch_vec;

  // Flag: a live mismatch beats a software clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= 1'b0;
    end else if (mismatch_any) begin
      flag_q <= 1'b1;
    end else if (wr_main && !req_i.wdata[port_b_gpio_pkg::CHANGE_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // Change interrupt enable, gates the wake request
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      change_en_q <= 1'b0;
    end else if (wr_main) begin
      change_en_q <= req_i.wdata[port_b_gpio_pkg::CHANGE_EN_BIT];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= port_b_gpio_pkg::RDATA_IDLE;
    end else if (req_i.rd) begin
      case (req_i.addr)
        port_b_gpio_pkg::OFS_PORT_DATA:  rdata_q <= pin_val;
        port_b_gpio_pkg::OFS_DIRECTION:  rdata_q <= dir_q;
        port_b_gpio_pkg::OFS_LATCH:      rdata_q <= latch_q;
        port_b_gpio_pkg::OFS_MAIN_INT:   rdata_q <= {4'h0, change_en_q, 2'h0, flag_q};
        port_b_gpio_pkg::OFS_SECOND_INT: rdata_q <= {pullup_dis_n_q, 7'h00};
        port_b_gpio_pkg::OFS_ANALOG_SEL: rdata_q <= {3'h0, analog_q};
        default:                         rdata_q <= port_b_gpio_pkg::RDATA_IDLE;
      endcase
    end else begin
      rdata_q <= port_b_gpio_pkg::RDATA_IDLE;
    end
  end

  // Per-pin drivers and pull-ups; registered so every output is a flop
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        pad_out_q[i]  <= 1'b0;
        pad_oe_n_q[i] <= 1'b1;
        pullup_q[i]   <= 1'b0;
      end else begin
        if ((i == port_b_gpio_pkg::CAPTURE_PIN) && !capture_sel_q) begin
          pad_out_q[i] <= capture_compare_unit_two_out_i;
        end else begin
          pad_out_q[i] <= latch_q[i];
        end
        pad_oe_n_q[i] <= dir_q[i];
        pullup_q[i]   <= !pullup_dis_n_q && dir_q[i];
      end
    end
  end

  // Interrupt and fault inputs see only input-mode digital pins; capture input takes digital pin 3 in either direction
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_irq_q    <= 3'h0;
      fault_q      <= 1'b0;
      capture_in_q <= 1'b0;
      analog_en_q  <= port_b_gpio_pkg::ANALOG_ON;
    end else begin
      ext_irq_q    <= pin_val[2:0] & dir_q[2:0];
      fault_q      <= pin_val[port_b_gpio_pkg::FAULT_PIN] && dir_q[port_b_gpio_pkg::FAULT_PIN];
      capture_in_q <= !capture_sel_q && pin_val[port_b_gpio_pkg::CAPTURE_PIN];
      analog_en_q  <= analog_q;
    end
  end

  // Wake is level; the power manager treats sleep and idle alike
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= flag_q && change_en_q;
    end
  end

  assign rdata_o                       = rdata_q;
  assign pad_out_o                     = pad_out_q;
  assign pad_oe_n_o                    = pad_oe_n_q;
  assign pullup_en_o                   = pullup_q;
  assign analog_en_o                   = analog_en_q;
  assign capture_compare_unit_two_in_o = capture_in_q;
  assign ext_irq_in_zero_o             = ext_irq_q[0];
  assign ext_irq_in_one_o              = ext_irq_q[1];
  assign ext_irq_in_two_o              = ext_irq_q[2];
  assign pwm_fault_input_o             = fault_q;
  assign port_change_flag_o            = flag_q;
  assign wake_o                        = wake_q;

  // Checks on the port behaviour
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_dir_write;
    wr_dir;
  endsequence

  sequence s_latch_write_quiet;
    wr_latch ##1 !wr_latch && !wr_data;
  endsequence

  sequence s_data_access;
    data_access;
  endsequence

  sequence s_pullup_on_write;
    wr_second && !req_i.wdata[7] && (dir_q == 8'hff) ##1 !wr_dir && !wr_second;
  endsequence

  a_dir_releases: assert property (
    s_dir_write |-> ##2 (pad_oe_n_o == $past(req_i.wdata, 2)))
    else $error("pad enables do not follow direction write");

  a_latch_drives: assert property (
    s_latch_write_quiet |-> ##1 (pad_out_o[2:0] == $past(req_i.wdata[2:0], 2)))
    else $error("driven pins do not show latch value");

  a_latch_readback: assert property (
    (req_i.rd && req_i.addr == 8'h08) |=> (rdata_o == $past(latch_q)))
    else $error("latch read does not return latched value");

  a_pullup_all_on: assert property (
    s_pullup_on_write |-> ##1 (pullup_en_o == 8'hff))
    else $error("pull-ups not all enabled after control clear");

  a_pullup_output_off: assert property (
    (pullup_en_o & ~$past(dir_q)) == 8'h00)
    else $error("pull-up active on an output pin");

  a_pullup_reset_off: assert property (
    (cfg_state_q == port_b_gpio_pkg::CFG_WAIT) |-> (pullup_en_o == 8'h00))
    else $error("pull-ups on right after reset");

  a_strap_loaded: assert property (
    $rose(cfg_state_q == port_b_gpio_pkg::CFG_DONE) |->
      (analog_q == ($past(analog_default_config_i) ? 5'h1f : 5'h00)))
    else $error("analog default not taken from strap");

  a_analog_reads_zero: assert property (
    (req_i.rd && req_i.addr == 8'h00 && analog_q == 5'h1f) |=> (rdata_o[4:0] == 5'h00))
    else $error("analog pin reads nonzero");

  // Pin 7 driven while its neighbours sit at the snapshot: nothing may mismatch
  a_output_excluded: assert property (
    (!dir_q[7] && (pin_val[6:4] == snap_q[2:0])) |-> !mismatch_any)
    else $error("output pin takes part in change compare");

  a_snap_refresh: assert property (
    s_data_access |=> (snap_q == $past(pin_val[7:4])))
    else $error("snapshot not refreshed on data access");

  a_memmove_skip: assert property (
    (wr_data && req_i.mem_move && !(req_i.rd)) |=> $stable(snap_q))
    else $error("memory move write refreshed snapshot");

  a_flag_sets: assert property (
    mismatch_any |=> flag_q)
    else $error("flag not set the cycle after a mismatch");

  a_self_clear: assert property (
    (pin_val[7:4] == snap_q) |-> !mismatch_any)
    else $error("mismatch stays after pin returned");

  a_clear_holds: assert property (
    (s_data_access ##[1:2] (!mismatch_any && wr_main && !req_i.wdata[0])) |=> !flag_q)
    else $error("clear after access did not hold");

  a_wake_follows: assert property (
    (flag_q && change_en_q) |=> wake_o)
    else $error("wake not raised by change interrupt");

  a_capture_route: assert property (
    (!capture_sel_q && !dir_q[3] && $stable(capture_sel_q))
      |=> (pad_out_o[3] == $past(capture_compare_unit_two_out_i)))
    else $error("pin 3 not driven by capture unit");

  a_ext_irq_gate: assert property (
    (dir_q[0] == 1'b0) |=> !ext_irq_in_zero_o && !pwm_fault_input_o)
    else $error("output pin 0 feeds alternate inputs");

endmodule

// ==== logic/port_b_gpio_pkg.sv ====
// Constants, register map and carrier types for the second GPIO port.
// Assumes a single 100 MHz clock and a byte-wide register port.
package port_b_gpio_pkg;

  // Port geometry
  localparam int unsigned PORT_W      = 8;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ANALOG_W    = 5;
  localparam int unsigned CHANGE_LO   = 4;
  localparam int unsigned CHANGE_W    = 4;
  localparam int unsigned EXT_IRQ_W   = 3;
  localparam int unsigned CAPTURE_PIN = 3;
  localparam int unsigned FAULT_PIN   = 0;

  // Register byte addresses
  localparam logic [7:0] OFS_PORT_DATA  = 8'h00;
  localparam logic [7:0] OFS_DIRECTION  = 8'h04;
  localparam logic [7:0] OFS_LATCH      = 8'h08;
  localparam logic [7:0] OFS_MAIN_INT   = 8'h0c;
  localparam logic [7:0] OFS_SECOND_INT = 8'h10;
  localparam logic [7:0] OFS_ANALOG_SEL = 8'h14;

  // Field positions
  localparam int unsigned CHANGE_FLAG_BIT = 0;
  localparam int unsigned CHANGE_EN_BIT   = 3;
  localparam int unsigned PULLUP_DIS_BIT  = 7;

  // Reset values
  localparam logic [7:0] DIR_RST        = 8'hff;
  localparam logic [7:0] LATCH_RST      = 8'h00;
  localparam logic       PULLUP_DIS_RST = 1'b1;
  localparam logic       CAPTURE_RST    = 1'b1;
  localparam logic [4:0] ANALOG_ON      = 5'h1f;
  localparam logic [4:0] ANALOG_OFF     = 5'h00;
  localparam logic [7:0] RDATA_IDLE     = 8'h00;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;     // Byte address
    logic [7:0] wdata;    // Write data
    logic       wr;       // Write strobe
    logic       rd;       // Read strobe
    logic       mem_move; // Write is the destination of a memory-to-memory move
  } reg_req_t;

  // Configuration capture after reset release
  typedef enum logic [1:0] {
    CFG_WAIT = 2'b01,
    CFG_DONE = 2'b10
  } cfg_state_t;

endpackage
